//--- rtl/fcd_defines.svh
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define FCD_CTRL_LOW_OFS 8'h0c
`define FCD_STATUS_HIGH_OFS 8'h0e

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FCD_CTRL_RESET 16'h0000
`define FCD_STATUS_RESET 16'h0000

// ----------------------------------------------------------------------
// Field positions, control register
// ----------------------------------------------------------------------
`define FCD_STEP_MSB 9
`define FCD_SM_BIT 11
`define FCD_SC_LSB 12
`define FCD_DM_LSB 14
`define FCD_CTRL_RSVD_BIT 10

// ----------------------------------------------------------------------
// Field positions, status register
// ----------------------------------------------------------------------
`define FCD_RESULT_MSB 9
`define FCD_HALT_GRANT_FLAG_BIT 12
`define FCD_HALT_REQUEST_FLAG_BIT 13
`define FCD_HW_RELEASE_ENABLE_BIT 14
`define FCD_CLOCK_GATE_OFF_BIT 15

// ----------------------------------------------------------------------
// Counter values and timing
// ----------------------------------------------------------------------
`define FCD_RESULT_MAX 10'h3ff
`define FCD_RESULT_ZERO 10'h000
`define FCD_GRANT_DELAY_CYC 1

`endif

//--- rtl/fcd_pkg.sv
package fcd_pkg;

  // --------------------------------------------------------------------
  // Divider mode field encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCD_DM_OFF_CLR = 2'h0, // Off, downstream clear high
    FCD_DM_NORMAL = 2'h1, // Reload counter
    FCD_DM_FRAC = 2'h2, // Accumulator
    FCD_DM_OFF = 2'h3 // Off, no clear
  } fcd_dm_t;

  // --------------------------------------------------------------------
  // Suspend control field encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCD_SC_RUN = 2'h0, // Generation continues
    FCD_SC_HOLD = 2'h1, // Stop, result held
    FCD_SC_RELOAD = 2'h2, // Stop, result to max
    FCD_SC_RELOAD_CLR = 2'h3 // As reload, plus downstream clear
  } fcd_sc_t;

  // Control register image, same layout as the register
  typedef struct packed {
    fcd_dm_t dm;
    fcd_sc_t sc;
    logic sm;
    logic rsvd;
    logic [9:0] step;
  } fcd_ctrl_t;

  // Status register image, same layout as the register
  typedef struct packed {
    logic clockGateOff;
    logic hwReleaseEnable;
    logic haltRequestFlag;
    logic haltGrantFlag;
    logic [1:0] rsvd;
    logic [9:0] result;
  } fcd_status_t;

endpackage

//--- rtl/fcd_step_engine.sv
`timescale 1ns/100ps
`include "fcd_defines.svh"

// ----------------------------------------------------------------------
// Reload counter and fractional accumulator
// ----------------------------------------------------------------------
module fcd_step_engine
  import fcd_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input wire logic clock,
  input wire logic rstn,
  input wire fcd_dm_t mode, // Selected divider mode
  input wire logic run, // Advance this cycle
  input wire logic forceMax, // Load result with all ones
  input wire logic [WIDTH-1:0] step, // Reload or addend
  output logic [WIDTH-1:0] result, // Counter or accumulator
  output logic outEnable // One-cycle enable pulse
);

  logic [WIDTH:0] fracSum; // Sum with carry out
  logic wrap; // Counter at its top value

  assign fracSum = {1'b0, result} + {1'b0, step};
  assign wrap = (result == `FCD_RESULT_MAX);

  // Result update; the mode-write load beats counting
  always_ff @(posedge clock) begin
    if (!rstn) begin
      result <= `FCD_RESULT_ZERO;
    end else if (forceMax) begin
      result <= `FCD_RESULT_MAX;
    end else if (run && mode == FCD_DM_NORMAL) begin
      // Wrap reloads the step value
      result <= wrap ? step : result + 10'h001;
    end else if (run && mode == FCD_DM_FRAC) begin
      result <= fracSum[WIDTH-1:0];
    end
  end

  // Enable pulse, registered so the gate sees a clean level
  always_ff @(posedge clock) begin
    if (!rstn) begin
      outEnable <= 1'b0;
    end else if (forceMax || !run) begin
      outEnable <= 1'b0;
    end else if (mode == FCD_DM_NORMAL) begin
      outEnable <= wrap;
    end else begin
      // Carry spreads pulses, jitter one input period at most
      outEnable <= fracSum[WIDTH];
    end
  end

endmodule

//--- rtl/fcd_suspend_ctrl.sv
`timescale 1ns/100ps
`include "fcd_defines.svh"

// ----------------------------------------------------------------------
// Debug halt handshake and suspend decision
// ----------------------------------------------------------------------
module fcd_suspend_ctrl
  import fcd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic debugHaltRequest, // High asks for suspend
  input wire logic debugHaltGrant_n, // Low when kernel grants
  input wire logic immediateSuspendSelect, // Skip the grant
  input wire fcd_sc_t suspendControl, // Suspend behaviour
  output logic haltRequestFlag, // Latched request
  output logic haltGrantFlag, // Latched grant, active high
  output logic suspended // Divider is in suspend
);

  // Latch both inputs every cycle for the status register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      haltRequestFlag <= 1'b0;
      haltGrantFlag <= 1'b0;
    end else begin
      haltRequestFlag <= debugHaltRequest;
      haltGrantFlag <= !debugHaltGrant_n;
    end
  end

  // Granted entry uses the latched grant, one cycle late;
  // immediate entry follows the live request
  assign suspended = (suspendControl != FCD_SC_RUN) && debugHaltRequest
                     && (immediateSuspendSelect || haltGrantFlag);

endmodule

//--- rtl/fcd_top.sv
// Summary of operation
// - Normal mode counts up, wraps, reloads step
// - Normal output rate is input over 1024-step
// - Fractional mode adds step, pulses on overflow
// - Fractional average rate step/1024, one-clock jitter
// - Module clock is enable ANDed with clock
// - Mode field selects off, normal, fractional, off
// - Writing normal or fractional mode loads max
// - Halt request high allows suspend per settings
// - Granted suspend entered one clock after grant
// - Immediate select enters suspend without grant
// - Request and grant latched into status bits
// - Suspend held only while request and grant/select
// - Suspend control picks continue, hold, reload, clear
// - Registers stay accessible while suspended
// - Module-off request raises core stop request
// - Clock-gate-off bit stops and silences divider
// - Hardware release clears gate-off when enabled
// - Outside release input is tied low here
// - Step and result are ten bits each
// - Reserved bits read zero, written zero
// - Configuration split over two 16-bit registers
// - Debug halt request also raises core stop
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "fcd_defines.svh"

module fcd_top
  import fcd_pkg::*;
#(
  parameter bit RELEASE_TIED_LOW = 1'b1, // Outside release wired to zero
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regReadData,
  input wire logic debugHaltRequest,
  input wire logic debugHaltGrant_n,
  input wire logic moduleOffRequest,
  input wire logic outsideClockRelease,
  output logic coreStopRequest,
  output logic downstreamDividerClear,
  output logic outEnable,
  output logic moduleClock
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  fcd_ctrl_t ctrl_q; // Lower control register
  fcd_status_t status; // Upper register image
  logic hwReleaseEnable_q; // Hardware release enable
  logic clockGateOff_q; // Software clock disable
  logic [15:0] readData_q; // Answer one cycle after read
  logic [9:0] result; // Engine counter value
  logic haltRequestFlag; // Latched request
  logic haltGrantFlag; // Latched grant
  logic suspended; // Suspend decision
  logic writeCtrl; // Write to lower register
  logic writeStatus; // Write to upper register
  logic modeLoad; // Mode write that loads max
  logic suspendLoad; // Suspend that loads max
  logic suspendStop; // Suspend that halts output
  logic run; // Engine advances
  logic releaseIn; // Effective outside release
  logic gateEnable_q; // Enable copy, changes with clock low

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------

  // Active divider modes, used in several places
  function automatic logic isActiveMode(input fcd_dm_t dm);
    return (dm == FCD_DM_NORMAL) || (dm == FCD_DM_FRAC);
  endfunction

  // Address match for one register
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr,
                                input logic [ADDR_WIDTH-1:0] ofs);
    return addr == ofs;
  endfunction

  assign writeCtrl = regWrite && hits(regAddr, `FCD_CTRL_LOW_OFS);
  assign writeStatus = regWrite && hits(regAddr, `FCD_STATUS_HIGH_OFS);

  // Both registers stay live in suspend; only the engine freezes

  // --------------------------------------------------------------------
  // Lower control register
  // --------------------------------------------------------------------

  // Control fields; reserved bit forced to zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q <= `FCD_CTRL_RESET;
    end else if (writeCtrl) begin
      ctrl_q <= regWriteData;
      ctrl_q.rsvd <= 1'b0;
    end
  end

  // A write that selects an active mode loads the result
  assign modeLoad = writeCtrl
                    && isActiveMode(fcd_dm_t'(regWriteData[`FCD_DM_LSB+1:`FCD_DM_LSB]));

  // --------------------------------------------------------------------
  // Upper register, writable bits
  // --------------------------------------------------------------------

  // Release input is forced low in this instance
  assign releaseIn = RELEASE_TIED_LOW ? 1'b0 : outsideClockRelease;

  // Hardware release enable, plain read/write bit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hwReleaseEnable_q <= 1'b0;
    end else if (writeStatus) begin
      hwReleaseEnable_q <= regWriteData[`FCD_HW_RELEASE_ENABLE_BIT];
    end
  end

  // Clock disable; hardware release wins over a software set
  // because the release is a level and must hold the bit clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clockGateOff_q <= 1'b0;
    end else if (hwReleaseEnable_q && releaseIn) begin
      clockGateOff_q <= 1'b0;
    end else if (writeStatus) begin
      clockGateOff_q <= regWriteData[`FCD_CLOCK_GATE_OFF_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Suspend handling
  // --------------------------------------------------------------------
  fcd_suspend_ctrl u_suspend (
    .clock(clock),
    .rstn(rstn),
    .debugHaltRequest(debugHaltRequest),
    .debugHaltGrant_n(debugHaltGrant_n),
    .immediateSuspendSelect(ctrl_q.sm),
    .suspendControl(ctrl_q.sc),
    .haltRequestFlag(haltRequestFlag),
    .haltGrantFlag(haltGrantFlag),
    .suspended(suspended)
  );

  // Any nonzero control stops output; reload codes load max
  assign suspendStop = suspended && (ctrl_q.sc != FCD_SC_RUN);
  assign suspendLoad = suspended
                       && (ctrl_q.sc == FCD_SC_RELOAD || ctrl_q.sc == FCD_SC_RELOAD_CLR);

  // Core stop answers either source, whatever the settings
  assign coreStopRequest = moduleOffRequest || debugHaltRequest;

  // --------------------------------------------------------------------
  // Step engine
  // --------------------------------------------------------------------

  // Engine runs only in an active mode, not stopped, not disabled
  assign run = isActiveMode(ctrl_q.dm) && !suspendStop && !clockGateOff_q;

  fcd_step_engine #(
    .WIDTH(10)
  ) u_engine (
    .clock(clock),
    .rstn(rstn),
    .mode(ctrl_q.dm),
    .run(run),
    .forceMax(modeLoad || suspendLoad),
    .step(ctrl_q.step),
    .result(result),
    .outEnable(outEnable)
  );

  // Downstream clear for off-with-clear mode or reload-with-clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      downstreamDividerClear <= 1'b1;
    end else begin
      downstreamDividerClear <= (ctrl_q.dm == FCD_DM_OFF_CLR)
                                || (suspended && ctrl_q.sc == FCD_SC_RELOAD_CLR);
    end
  end

  // --------------------------------------------------------------------
  // Module clock gate
  // --------------------------------------------------------------------

  // Enable is retimed on the falling edge so the AND below never
  // sees it change while the clock is high; a raw AND would glitch
  always_ff @(negedge clock) begin
    if (!rstn) begin
      gateEnable_q <= 1'b0;
    end else begin
      gateEnable_q <= outEnable;
    end
  end

  assign moduleClock = clock & gateEnable_q;

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_comb begin
    status = `FCD_STATUS_RESET;
    status.clockGateOff = clockGateOff_q;
    status.hwReleaseEnable = hwReleaseEnable_q;
    status.haltRequestFlag = haltRequestFlag;
    status.haltGrantFlag = haltGrantFlag;
    status.result = result;
  end

  // Data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      readData_q <= 16'h0000;
    end else if (regRead && hits(regAddr, `FCD_CTRL_LOW_OFS)) begin
      readData_q <= ctrl_q;
    end else if (regRead && hits(regAddr, `FCD_STATUS_HIGH_OFS)) begin
      readData_q <= status;
    end else begin
      readData_q <= 16'h0000;
    end
  end

  assign regReadData = readData_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------

  // Normal wrap gives a pulse and reloads the step value
  property p_normal_wrap;
    @(posedge clock) disable iff (!rstn)
      (run && ctrl_q.dm == FCD_DM_NORMAL && result == 10'h3ff && !modeLoad && !suspendLoad)
      |=> (outEnable && result == $past(ctrl_q.step));
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal wrap did not pulse and reload");

  // Below the top the counter steps by one with no pulse
  property p_normal_count;
    @(posedge clock) disable iff (!rstn)
      (run && ctrl_q.dm == FCD_DM_NORMAL && result != 10'h3ff && !modeLoad && !suspendLoad)
      |=> (!outEnable && result == $past(result) + 10'h001);
  endproperty
  a_normal_count: assert property (p_normal_count)
    else $error("normal counter did not step by one");

  // Step of all ones pulses on every cycle while running
  property p_full_rate;
    @(posedge clock) disable iff (!rstn)
      (run && ctrl_q.dm == FCD_DM_NORMAL && ctrl_q.step == 10'h3ff && result == 10'h3ff
       && !writeCtrl && !suspendLoad)[*2] |=> outEnable;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("full rate step missed a pulse");

  // Fractional mode adds step and pulses on the carry
  property p_frac_add;
    @(posedge clock) disable iff (!rstn)
      (run && ctrl_q.dm == FCD_DM_FRAC && !modeLoad && !suspendLoad)
      |=> ({outEnable, result} == {1'b0, $past(result)} + {1'b0, $past(ctrl_q.step)});
  endproperty
  a_frac_add: assert property (p_frac_add)
    else $error("fractional sum or carry wrong");

  // Writing an active mode loads the top value
  property p_mode_load;
    @(posedge clock) disable iff (!rstn)
      modeLoad |=> (result == 10'h3ff && !outEnable);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode write did not load result");

  // Off-with-clear mode drives the downstream clear
  property p_off_clear;
    @(posedge clock) disable iff (!rstn)
      (ctrl_q.dm == FCD_DM_OFF_CLR) |=> downstreamDividerClear;
  endproperty
  a_off_clear: assert property (p_off_clear)
    else $error("downstream clear low in off-with-clear mode");

  // Granted entry follows a held grant by one cycle
  property p_granted_entry;
    @(posedge clock) disable iff (!rstn)
      (ctrl_q.sc != FCD_SC_RUN && !ctrl_q.sm && debugHaltRequest && !debugHaltGrant_n
       && !writeCtrl)
      ##1 (debugHaltRequest) |-> suspended;
  endproperty
  a_granted_entry: assert property (p_granted_entry)
    else $error("granted suspend not entered one cycle after grant");

  // Immediate select enters on the request itself
  property p_immediate;
    @(posedge clock) disable iff (!rstn)
      (ctrl_q.sc != FCD_SC_RUN && ctrl_q.sm && debugHaltRequest) |-> suspended;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate suspend not entered");

  // Status flags mirror the inputs of the previous cycle
  property p_flags;
    @(posedge clock) disable iff (!rstn)
      1'b1 |=> (haltRequestFlag == $past(debugHaltRequest)
                && haltGrantFlag == !$past(debugHaltGrant_n));
  endproperty
  a_flags: assert property (p_flags)
    else $error("status flags do not follow inputs");

  // Dropping the request leaves suspend at once
  property p_leave;
    @(posedge clock) disable iff (!rstn)
      !debugHaltRequest |-> !suspended;
  endproperty
  a_leave: assert property (p_leave)
    else $error("suspended without a request");

  // Hold code freezes the result and the output
  property p_hold;
    @(posedge clock) disable iff (!rstn)
      (suspended && ctrl_q.sc == FCD_SC_HOLD && !modeLoad)
      |=> (result == $past(result) && !outEnable);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold suspend changed result or pulsed");

  // Core stop follows either source
  property p_core_stop;
    @(posedge clock) disable iff (!rstn)
      (moduleOffRequest || debugHaltRequest) |-> coreStopRequest;
  endproperty
  a_core_stop: assert property (p_core_stop)
    else $error("core stop request missing");

  // Disabled divider stays quiet and keeps its result
  property p_gate_off;
    @(posedge clock) disable iff (!rstn)
      (clockGateOff_q && !modeLoad && !suspendLoad)
      |=> (!outEnable && result == $past(result));
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("disabled divider moved or pulsed");

  // Reserved bits of the upper register read zero
  property p_rsvd_zero;
    @(posedge clock) disable iff (!rstn)
      (regRead && regAddr == `FCD_STATUS_HIGH_OFS) |=> (regReadData[11:10] == 2'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bits not zero");

endmodule

//--- testbench/fcd_kernel_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Kernel model: grants a halt after a set delay
// ----------------------------------------------------------------------
module fcd_kernel_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic coreStopRequest, // Stop asked of the kernel
  input wire logic [7:0] grantDelay, // Cycles to grant, ff never
  output logic debugHaltGrant_n // Low while granted
);
  logic [7:0] waitQ; // Cycles the request has stood

  // Grant only once the stop request has stood long enough
  always_ff @(posedge clock) begin
    if (!rstn || !coreStopRequest) begin
      waitQ <= 8'h00;
      debugHaltGrant_n <= 1'b1;
    end else begin
      waitQ <= (waitQ == 8'hff) ? waitQ : waitQ + 8'h01;
      debugHaltGrant_n <= !(waitQ >= grantDelay && grantDelay != 8'hff);
    end
  end
endmodule

//--- testbench/fractional_clock_enable_divider_tb.sv
`timescale 1ns/100ps

module fractional_clock_enable_divider_tb;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWriteData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic debugHaltRequest = 1'b0;
  logic moduleOffRequest = 1'b0;
  logic outsideClockRelease = 1'b0;
  logic [7:0] grantDelay = 8'h03; // Prompt kernel by default
  logic [15:0] regReadData;
  logic debugHaltGrant_n, coreStopRequest, downstreamDividerClear, outEnable, moduleClock;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h2f70;
  int n; // Pulses seen in a window
  logic [15:0] rdv; // Last read data
  logic [15:0] prv; // Earlier read data
  logic [9:0] st; // Step under test

  always #5 clock = ~clock;

  fcd_top fcd_top_i (.clock(clock), .rstn(rstn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .debugHaltRequest(debugHaltRequest),
    .debugHaltGrant_n(debugHaltGrant_n), .moduleOffRequest(moduleOffRequest),
    .outsideClockRelease(outsideClockRelease), .coreStopRequest(coreStopRequest),
    .downstreamDividerClear(downstreamDividerClear), .outEnable(outEnable),
    .moduleClock(moduleClock));

  fcd_kernel_model fcd_kernel_model_i (.clock(clock), .rstn(rstn),
    .coreStopRequest(coreStopRequest), .grantDelay(grantDelay),
    .debugHaltGrant_n(debugHaltGrant_n));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobes, launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdv = regReadData;
  endtask

  task automatic pulses(input int len);
    n = 0;
    repeat (len) begin
      @(posedge clock);
      #1 n += int'(outEnable);
    end
  endtask

  function automatic logic [15:0] ctl(input logic [1:0] dm, sc, input logic sm,
                                      input logic [9:0] s);
    return {dm, sc, sm, 1'b0, s};
  endfunction

  // Pulses in a whole-period window: normal len/(1024-step), fractional step
  function automatic logic [15:0] expect_pulses(input logic [1:0] dm, input logic [9:0] s,
                                                input int len);
    return (dm == 2'h1) ? 16'(len / (1024 - int'(s))) : 16'(s);
  endfunction

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end

  // Gated clock must be low through every low phase
  always @(negedge clock) begin
    #2 chk(16'(moduleClock), 16'h0000);
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h0c); chk(rdv, 16'h0000);
    rd(8'h0e); chk(rdv, 16'h0000);
    rd(8'h10); chk(rdv, 16'h0000);
    chk(16'(downstreamDividerClear), 16'h0001);
    $display("reset test done");
    // Gate off; release input has no path here, mode write still loads max
    outsideClockRelease <= 1'b1;
    wr(8'h0e, 16'hffff);
    wr(8'h0c, ctl(2'h1, 2'h0, 1'b0, 10'h3f0) | 16'h0400);
    rd(8'h0e); chk(rdv, 16'hc3ff);
    rd(8'h0c); chk(rdv, 16'h43f0);
    pulses(32); chk(16'(n), 16'h0000);
    outsideClockRelease <= 1'b0;
    wr(8'h0e, 16'h0000);
    $display("gate test done");
    // Normal and fractional, corner steps first then random ones
    for (int i = 0; i < 7; i++) begin
      st = (i == 0 || i == 4) ? 10'h3fd - 10'(i) * 10'h0ff : 10'($random(seed));
      if (i == 1) st = 10'h3ff;
      if (i < 4) st = st | 10'h3f0;
      wr(8'h0c, ctl(i < 4 ? 2'h1 : 2'h2, 2'h0, 1'b0, st));
      pulses(4);
      pulses(i < 4 ? 8 * (1024 - int'(st)) : 1024);
      chk(16'(n), expect_pulses(i < 4 ? 2'h1 : 2'h2, st, i < 4 ? 8 * (1024 - int'(st)) : 1024));
    end
    $display("divider test done");
    // Both switched-off codes: no pulses, result frozen
    for (int m = 0; m < 4; m += 3) begin
      wr(8'h0c, ctl(2'(m), 2'h0, 1'b0, 10'h3f0));
      rd(8'h0e); prv = rdv;
      pulses(40);
      rd(8'h0e); chk(rdv, prv);
      chk(16'(n), 16'h0000);
      chk(16'(downstreamDividerClear), 16'(m == 0));
    end
    $display("off test done");
    // Granted suspend with every suspend control code
    for (int sc = 0; sc < 4; sc++) begin
      wr(8'h0c, ctl(2'h1, 2'(sc), 1'b0, 10'h3f0));
      debugHaltRequest <= 1'b1;
      pulses(8);
      chk(16'(coreStopRequest), 16'h0001);
      rd(8'h0e); prv = rdv;
      chk(prv & 16'hf000, 16'h3000);
      pulses(32);
      rd(8'h0e); chk(sc == 1 ? prv : sc > 1 ? 16'h33ff : rdv, rdv);
      chk(16'(n), sc == 0 ? 16'h0002 : 16'h0000);
      chk(16'(downstreamDividerClear), 16'(sc == 3));
      wr(8'h0c, ctl(2'h1, 2'(sc), 1'b0, 10'h3f8));
      rd(8'h0c); chk(rdv, ctl(2'h1, 2'(sc), 1'b0, 10'h3f8));
      debugHaltRequest <= 1'b0;
      pulses(8);
      pulses(32); chk(16'(n), expect_pulses(2'h1, 10'h3f8, 32));
    end
    $display("granted suspend test done");
    // Immediate suspend while the kernel never grants
    grantDelay <= 8'hff;
    wr(8'h0c, ctl(2'h1, 2'h1, 1'b1, 10'h3f0));
    debugHaltRequest <= 1'b1;
    pulses(3);
    pulses(32); chk(16'(n), 16'h0000);
    rd(8'h0e); chk(rdv & 16'hf000, 16'h2000);
    debugHaltRequest <= 1'b0;
    moduleOffRequest <= 1'b1;
    pulses(1); chk(16'(coreStopRequest), 16'h0001);
    moduleOffRequest <= 1'b0;
    $display("immediate suspend test done");
    give_verdict;
  end
endmodule
